// [common/gsrc_defines.svh]
/*
 * Constants for the satellite record formatter: byte offsets, sizes, field codes, register map.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef GSRC_DEFINES_SVH
`define GSRC_DEFINES_SVH

// ============================================================
// Record layout
`define GSRC_SUM_HDR_LEN     8'h02
`define GSRC_SUM_ELEM_LEN    8'h08
`define GSRC_RAW_HDR_LEN     8'h0C
`define GSRC_RAW_ELEM_LEN    8'h1C
`define GSRC_RAW_WEEK_OFS    8'h08
`define GSRC_RAW_COUNT_OFS   8'h0A
`define GSRC_RESERVED_BYTE   8'h00

// ============================================================
// Summary flag bits
`define GSRC_FLG_HEALTHY     0
`define GSRC_FLG_ALMANAC     1
`define GSRC_FLG_EPHEMERIS   2
`define GSRC_FLG_DIFF        3
`define GSRC_FLG_NAV         4
`define GSRC_FLG_AZEL        5
`define GSRC_FLG_RTK         6
`define GSRC_FLG_MASK        8'h7F

// ============================================================
// Code limits
`define GSRC_CONST_MAX       8'h06
`define GSRC_BAND_MAX        8'h06
`define GSRC_CHAN_MAX        8'h0E
`define GSRC_QUAL_MAX        8'h07

// ============================================================
// Register map (byte addresses)
`define GSRC_REG_CTRL        4'h0
`define GSRC_REG_STATUS      4'h4
`define GSRC_REG_COUNT       4'h8
`define GSRC_CTRL_RESET      32'h0000_0000

`endif

// [common/gsrc_pkg.sv]
/*
 * Types for the satellite record formatter.
 * Assumes gsrc_defines.svh is on the include path.
 */
`include "gsrc_defines.svh"
package gsrc_pkg;
	// Record kind selected by software
	typedef enum logic [1:0] {GSRC_SUMMARY = 2'b01, GSRC_RAW = 2'b10} gsrc_kind_t;

	// Formatter states, one-hot
	typedef enum logic [3:0] {
		GSRC_IDLE = 4'b0001,
		GSRC_HDR  = 4'b0010,
		GSRC_ELEM = 4'b0100,
		GSRC_DONE = 4'b1000
	} gsrc_state_t;

	// One summary element as supplied by the tracking logic
	typedef struct packed {
		logic [7:0]  constellation;
		logic [7:0]  vehicle_id;
		logic [7:0]  track_flags;
		logic [7:0]  cn0_dbhz;
		logic [7:0]  quality_code;
		logic [7:0]  elevation_deg;
		logic [15:0] azimuth_deg;
	} gsrc_sum_elem_t;

	// One raw satellite element
	typedef struct packed {
		logic [7:0]  constellation;
		logic [7:0]  vehicle_id;
		logic [7:0]  band_code;
		logic [7:0]  channel_code;
		logic [7:0]  slot_id;
		logic [7:0]  cn0_dbhz;
		logic [15:0] track_flags;
		logic [63:0] pseudorange;
		logic [63:0] carrier_phase;
		logic [31:0] doppler_shift;
	} gsrc_raw_elem_t;

	// Byte on the output stream
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} gsrc_byte_t;
endpackage

// [hdl/gsrc_codec.sv]
/*
 * Satellite record formatter: builds summary or raw measurement records as a byte stream.
 * Assumes elements arrive on a valid/ready port from same-clock logic, and an AXI4-Lite master.
 */
// Operation
// RULE1 - Summary: count byte, reserved byte, then elements
// RULE2 - Summary element eight bytes, fixed field order
// RULE3 - Signal strength byte carries C/N0 dB-Hz
// RULE4 - Summary flags bits zero to six defined
// RULE5 - Quality code zero to seven as listed
// RULE6 - Elevation and azimuth in whole degrees
// RULE7 - Summary length two plus eight per satellite
// RULE8 - Parser reads count first for length
// RULE9 - Raw header: time, week, count, reserved
// RULE10 - Time in seconds, GPS week, element count
// RULE11 - Raw element 28 bytes, fixed field order
// RULE12 - Meters, cycles, hertz; Doppler positive approaching
// RULE13 - Constellation codes zero to six
// RULE14 - Band codes zero to six
// RULE15 - Channel codes zero to fourteen
// RULE16 - Raw length twelve plus 28 per satellite
// RULE17 - Little-endian integers, IEEE-754 floats
`timescale 1ns/1ps
`include "gsrc_defines.svh"
module gsrc_codec
	import gsrc_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Record header inputs, held for the whole record
	input  wire logic [63:0]      tow_seconds,
	input  wire logic [15:0]      gps_week,
	// Element input
	input  wire logic             elem_valid,
	output logic                  elem_ready,
	input  wire gsrc_sum_elem_t   sum_elem,
	input  wire gsrc_raw_elem_t   raw_elem,
	// Byte stream output
	output logic                  out_valid,
	input  wire logic             out_ready,
	output gsrc_byte_t            out_byte,
	// AXI4-Lite slave
	input  wire logic [3:0]       s_awaddr,
	input  wire logic             s_awvalid,
	output logic                  s_awready,
	input  wire logic [31:0]      s_wdata,
	input  wire logic [3:0]       s_wstrb,
	input  wire logic             s_wvalid,
	output logic                  s_wready,
	output logic [1:0]            s_bresp,
	output logic                  s_bvalid,
	input  wire logic             s_bready,
	input  wire logic [3:0]       s_araddr,
	input  wire logic             s_arvalid,
	output logic                  s_arready,
	output logic [31:0]           s_rdata,
	output logic [1:0]            s_rresp,
	output logic                  s_rvalid,
	input  wire logic             s_rready
);
	// ============================================================
	// Registers
	logic [31:0]      ctrl_reg;        // [0] start pulse, [1] raw kind, [15:8] sat_count
	logic             busy_reg;
	logic [15:0]      rec_count_reg;   // Records completed
	gsrc_state_t      state_reg;
	logic [7:0]       idx_reg;         // Byte index within header or element
	logic [7:0]       sat_left_reg;
	logic [7:0]       sat_count_reg;
	logic             raw_reg;
	logic [223:0]     elem_sh_reg;     // Element bytes, byte 0 in low bits
	logic [1:0][8:0]  buf_reg;
	logic [1:0]       buf_cnt_reg;
	logic             wr_ptr_reg;
	logic             rd_ptr_reg;
	logic             aw_hold_reg;
	logic             w_hold_reg;
	logic [3:0]       aw_addr_reg;
	logic [31:0]      w_data_reg;
	logic             start_pulse;

	// ============================================================
	// AXI4-Lite write: address and data taken in either order
	assign s_awready = !aw_hold_reg && !s_bvalid;
	assign s_wready  = !w_hold_reg && !s_bvalid;
	assign s_bresp   = 2'h0;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg  <= 32'h0000_0000;
			s_bvalid    <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_wdata;
			end
			if (aw_hold_reg && w_hold_reg) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				s_bvalid    <= 1'b1;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Control register; start is self-clearing and ignored while busy
	assign start_pulse = aw_hold_reg && w_hold_reg && aw_addr_reg == `GSRC_REG_CTRL && w_data_reg[0] && !busy_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `GSRC_CTRL_RESET;
		end else if (aw_hold_reg && w_hold_reg && aw_addr_reg == `GSRC_REG_CTRL) begin
			ctrl_reg <= {16'h0000, w_data_reg[15:8], 6'h00, w_data_reg[1], 1'b0};
		end
	end

	// ============================================================
	// AXI4-Lite read; unmapped addresses read zero with OKAY
	assign s_arready = !s_rvalid;
	assign s_rresp   = 2'h0;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			case (s_araddr)
				`GSRC_REG_CTRL:   s_rdata <= ctrl_reg;
				`GSRC_REG_STATUS: s_rdata <= {20'h00000, state_reg, 7'h00, busy_reg};
				`GSRC_REG_COUNT:  s_rdata <= {16'h0000, rec_count_reg};
				default:          s_rdata <= 32'h0000_0000;
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ============================================================
	// Header byte picker; integers little-endian, time is binary64 as given
	function automatic logic [7:0] hdr_byte(input logic raw, input logic [7:0] i, input logic [7:0] n);
		logic [7:0] b;
		b = `GSRC_RESERVED_BYTE;
		if (!raw) begin
			if (i == 8'h00) b = n;                                        // RULE1 RULE8
		end else if (i < `GSRC_RAW_WEEK_OFS) begin
			b = tow_seconds[8*i[2:0] +: 8];                               // RULE9 RULE10 RULE17
		end else if (i < `GSRC_RAW_COUNT_OFS) begin
			b = gps_week[8*i[0] +: 8];                                    // RULE9 RULE10 RULE17
		end else if (i == `GSRC_RAW_COUNT_OFS) begin
			b = n;                                                        // RULE9 RULE10
		end
		return b;
	endfunction

	// ============================================================
	// Stream buffer flags
	logic       push;
	logic       buf_full;
	logic       hdr_last;
	logic       elem_last;
	logic [7:0] hdr_len;
	logic [7:0] elem_len;
	logic [8:0] push_word;
	assign buf_full  = buf_cnt_reg == 2'h2;
	assign hdr_len   = raw_reg ? `GSRC_RAW_HDR_LEN : `GSRC_SUM_HDR_LEN;     // RULE7 RULE16
	assign elem_len  = raw_reg ? `GSRC_RAW_ELEM_LEN : `GSRC_SUM_ELEM_LEN;   // RULE2 RULE11
	assign hdr_last  = idx_reg == hdr_len - 8'h01;
	assign elem_last = idx_reg == elem_len - 8'h01;
	assign push      = !buf_full && (state_reg == GSRC_HDR || state_reg == GSRC_ELEM);
	assign elem_ready = state_reg == GSRC_ELEM && idx_reg == elem_len;   // Only while waiting between elements

	// Byte being pushed; record ends on last element byte, or header byte when count is zero
	always_comb begin
		push_word = 9'h000;
		if (state_reg == GSRC_HDR) begin
			push_word = {hdr_byte(raw_reg, idx_reg, sat_count_reg), hdr_last && sat_count_reg == 8'h00};
		end else if (state_reg == GSRC_ELEM) begin
			push_word = {elem_sh_reg[8*idx_reg[4:0] +: 8], elem_last && sat_left_reg == 8'h01};
		end
	end

	// ============================================================
	// Element capture; the tracking logic already supplies degrees, dB-Hz and IEEE values
	logic        take_elem;
	logic [63:0] sum_bytes;
	logic [223:0] raw_bytes;
	assign take_elem = elem_ready && elem_valid;
	assign sum_bytes = {sum_elem.azimuth_deg, sum_elem.elevation_deg, sum_elem.quality_code,     // RULE5 RULE6
		sum_elem.cn0_dbhz, sum_elem.track_flags & `GSRC_FLG_MASK,                                // RULE3 RULE4
		sum_elem.vehicle_id, sum_elem.constellation};                                            // RULE2 RULE13
	assign raw_bytes = {raw_elem.doppler_shift, raw_elem.carrier_phase, raw_elem.pseudorange,   // RULE11 RULE12
		raw_elem.track_flags, raw_elem.cn0_dbhz, raw_elem.slot_id, raw_elem.channel_code,        // RULE15
		raw_elem.band_code, raw_elem.vehicle_id, raw_elem.constellation};                        // RULE14 RULE13

	// ============================================================
	// Formatter state machine; element index = elem_len means waiting for an element
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= GSRC_IDLE;
			idx_reg       <= 8'h00;
			sat_left_reg  <= 8'h00;
			sat_count_reg <= 8'h00;
			raw_reg       <= 1'b0;
			busy_reg      <= 1'b0;
			elem_sh_reg   <= 224'h0;
			rec_count_reg <= 16'h0000;
		end else begin
			case (state_reg)
				GSRC_IDLE: begin
					if (start_pulse) begin
						state_reg     <= GSRC_HDR;
						busy_reg      <= 1'b1;
						raw_reg       <= w_data_reg[1];
						sat_count_reg <= w_data_reg[15:8];
						sat_left_reg  <= w_data_reg[15:8];
						idx_reg       <= 8'h00;
					end
				end
				GSRC_HDR: begin
					if (push) begin
						idx_reg <= idx_reg + 8'h01;
						if (hdr_last) begin
							state_reg <= sat_count_reg == 8'h00 ? GSRC_DONE : GSRC_ELEM;
							idx_reg   <= elem_len;
						end
					end
				end
				GSRC_ELEM: begin
					if (take_elem) begin
						elem_sh_reg <= raw_reg ? raw_bytes : {160'h0, sum_bytes};
						idx_reg     <= 8'h00;
					end else if (push && idx_reg != elem_len) begin
						idx_reg <= idx_reg + 8'h01;
						if (elem_last) begin
							sat_left_reg <= sat_left_reg - 8'h01;
							idx_reg      <= elem_len;
							if (sat_left_reg == 8'h01) state_reg <= GSRC_DONE;
						end
					end
				end
				GSRC_DONE: begin
					state_reg     <= GSRC_IDLE;
					busy_reg      <= 1'b0;
					rec_count_reg <= rec_count_reg + 16'h0001;
				end
				default: state_reg <= GSRC_IDLE;
			endcase
		end
	end

	// ============================================================
	// Two-entry output buffer; a stalled receiver holds the formatter
	logic push_ok;
	logic pop;
	assign push_ok  = push && (state_reg == GSRC_HDR || idx_reg != elem_len);
	assign pop      = out_valid && out_ready;
	assign out_valid = buf_cnt_reg != 2'h0;
	assign out_byte = gsrc_byte_t'(buf_reg[rd_ptr_reg]);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buf_reg     <= '0;
			buf_cnt_reg <= 2'h0;
			wr_ptr_reg  <= 1'b0;
			rd_ptr_reg  <= 1'b0;
		end else begin
			if (push_ok) begin
				buf_reg[wr_ptr_reg] <= push_word;
				wr_ptr_reg          <= !wr_ptr_reg;
			end
			if (pop) rd_ptr_reg <= !rd_ptr_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, push_ok} - {1'b0, pop};
		end
	end

	// ============================================================
	// Checks
	logic [15:0] rec_bytes;   // Bytes pushed in the current record
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) rec_bytes <= 16'h0000;
		else if (start_pulse) rec_bytes <= 16'h0000;
		else if (push_ok) rec_bytes <= rec_bytes + 16'h0001;
	end
	logic [15:0] exp_len;
	assign exp_len = raw_reg ? 16'(`GSRC_RAW_HDR_LEN) + 16'(sat_count_reg) * 16'(`GSRC_RAW_ELEM_LEN)
		: 16'(`GSRC_SUM_HDR_LEN) + 16'(sat_count_reg) * 16'(`GSRC_SUM_ELEM_LEN);

	a_record_length: assert property (@(posedge sys_clk) disable iff (rst) // RULE7 RULE16
		push_ok && push_word[0] |-> rec_bytes + 16'h0001 == exp_len)
		else $error("record length mismatch");
	a_count_first: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
		push_ok && !raw_reg && state_reg == GSRC_HDR && idx_reg == 8'h00 |-> push_word[8:1] == sat_count_reg)
		else $error("summary count byte wrong");
	a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE1 RULE9
		push_ok && state_reg == GSRC_HDR && idx_reg == hdr_len - 8'h01 |-> push_word[8:1] == 8'h00)
		else $error("reserved byte not zero");
	a_raw_count: assert property (@(posedge sys_clk) disable iff (rst) // RULE9 RULE10
		push_ok && raw_reg && state_reg == GSRC_HDR && idx_reg == `GSRC_RAW_COUNT_OFS
		|-> push_word[8:1] == sat_count_reg)
		else $error("raw count byte wrong");
	a_week_lsb: assert property (@(posedge sys_clk) disable iff (rst) // RULE17
		push_ok && raw_reg && state_reg == GSRC_HDR && idx_reg == `GSRC_RAW_WEEK_OFS
		|-> push_word[8:1] == gps_week[7:0])
		else $error("week not low byte first");
	a_flag_bit7: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
		push_ok && !raw_reg && state_reg == GSRC_ELEM && idx_reg == 8'h02 |-> !push_word[8])
		else $error("undefined summary flag bit set");
	a_buf_stall: assert property (@(posedge sys_clk) disable iff (rst) // RULE2 RULE11
		out_valid && !out_ready |=> out_valid && $stable(out_byte))
		else $error("output byte changed while stalled");
	a_done_idle: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
		state_reg == GSRC_DONE |=> state_reg == GSRC_IDLE && !busy_reg)
		else $error("record did not close");
endmodule

// [tb/gsrc_host_model.sv]
/*
 * Host model that consumes the record byte stream and parses the record length from its count byte.
 * Assumes the formatter's clock and reset, and a kind select and a pace select from the bench.
 */
`timescale 1ns/1ps
module gsrc_host_model
	import gsrc_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Bench control
	input  wire logic       slow,
	input  wire logic       raw_kind,
	// Byte stream
	input  wire logic       out_valid,
	output logic            out_ready,
	input  wire gsrc_byte_t out_byte,
	// Parse results
	output logic [15:0]     rx_cnt,
	output logic [15:0]     rec_len,
	output logic            len_ok
);
	logic [1:0] pace_reg;
	logic       take;

	// Byte moves when both sides agree
	assign take = out_valid & out_ready;

	// ============================================================
	// Pacing
	// A slow host takes one cycle in three, so the buffer fills and must hold
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pace_reg  <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			pace_reg  <= (pace_reg == 2'h2) ? 2'h0 : pace_reg + 2'h1;
			out_ready <= !slow || (pace_reg == 2'h2);
		end
	end

	// ============================================================
	// Parser
	// Length is fixed by the count byte before any element is consumed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_cnt  <= 16'h0000;
			rec_len <= 16'h0000;
			len_ok  <= 1'b0;
		end else if (take) begin
			rx_cnt <= out_byte.last ? 16'h0000 : rx_cnt + 16'h0001;
			if (!raw_kind && rx_cnt == 16'h0000)
				rec_len <= 16'h0002 + {5'h00, out_byte.data, 3'h0};
			if (raw_kind && rx_cnt == 16'h000A)
				rec_len <= 16'h000C + {8'h00, out_byte.data} * 16'h001C;
			if (out_byte.last)
				len_ok <= (rx_cnt + 16'h0001 == rec_len);
		end
	end
endmodule

// [tb/test_gsrc_codec.sv]
/*
 * Self-checking bench for the record formatter: registers over AXI4-Lite, records checked byte by byte.
 * Assumes the host model in gsrc_host_model.sv and the shared package and defines.
 */
`timescale 1ns/1ps
`include "gsrc_defines.svh"
module test_gsrc_codec
	import gsrc_pkg::*;
;
	logic                 sys_clk, rst, elem_valid, elem_ready, out_valid, out_ready;
	logic [63:0]          tow_seconds;
	logic [15:0]          gps_week, rx_cnt, rec_len;
	gsrc_sum_elem_t       sum_elem;
	gsrc_raw_elem_t       raw_elem;
	gsrc_byte_t           out_byte;
	logic [3:0]           s_awaddr, s_araddr, s_wstrb;
	logic [31:0]          s_wdata, s_rdata, rd;
	logic [1:0]           s_bresp, s_rresp;
	logic                 s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic                 s_arvalid, s_arready, s_rvalid, s_rready, slow, raw_kind, len_ok;
	int                   n_mismatch, num_checks, cyc;
	gsrc_byte_t           exp_q[$];

	gsrc_codec uut (.sys_clk(sys_clk), .rst(rst), .tow_seconds(tow_seconds), .gps_week(gps_week),
		.elem_valid(elem_valid), .elem_ready(elem_ready), .sum_elem(sum_elem), .raw_elem(raw_elem),
		.out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

	gsrc_host_model host (.sys_clk(sys_clk), .rst(rst), .slow(slow), .raw_kind(raw_kind),
		.out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte), .rx_cnt(rx_cnt),
		.rec_len(rec_len), .len_ok(len_ok));

	// ============================================================
	// Checking and closing
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ============================================================
	// AXI4-Lite master: ready sampled mid-cycle, released just after the taking edge
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, aw_done, w_done, b_hs;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_hs = 1'b0;
		@(posedge sys_clk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge sys_clk);
			aw_hs = s_awvalid && s_awready;
			w_hs = s_wvalid && s_wready;
			@(posedge sys_clk);
			if (aw_hs) begin
				s_awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (w_hs) begin
				s_wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		while (!b_hs) begin
			@(negedge sys_clk);
			b_hs = (s_bvalid === 1'b1);
			@(posedge sys_clk);
		end
		chk("bresp", {30'h0, s_bresp}, 32'h0);
		s_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		logic ar_hs, r_hs;
		ar_hs = 1'b0;
		r_hs = 1'b0;
		@(posedge sys_clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		while (!ar_hs) begin
			@(negedge sys_clk);
			ar_hs = s_arready === 1'b1;
			@(posedge sys_clk);
		end
		s_arvalid <= 1'b0;
		while (!r_hs) begin
			@(negedge sys_clk);
			r_hs = s_rvalid === 1'b1;
			d = s_rdata;
			chk("rresp", {30'h0, s_rresp}, 32'h0);
			@(posedge sys_clk);
		end
		s_rready <= 1'b0;
	endtask

	// ============================================================
	// Element images: every code of a table is walked by the element index
	function automatic gsrc_sum_elem_t mk_sum(input logic [7:0] k);
		mk_sum = '{k % 8'h07, k + 8'h40, 8'hFF ^ k, 8'h20 + k, k, 8'hF8 + k, {k, 8'hA5}};
	endfunction

	function automatic gsrc_raw_elem_t mk_raw(input logic [7:0] k);
		mk_raw = '{k % 8'h07, k + 8'h01, k % 8'h07, k, 8'hFE, 8'h2D, {7'h00, k[0], k},
			{8'h41, k, 48'h7010_2030_4050}, {8'hC1, k, 48'h0102_0304_0506}, {k, 24'h40_2000}};
	endfunction

	// Element k stands until the formatter takes it; a record's last byte rewinds the index
	logic [7:0] feed_k_reg, feed_k_next;
	assign feed_k_next = (out_valid && out_ready && out_byte.last) ? 8'h00
		: feed_k_reg + {7'h00, elem_valid && elem_ready};
	always @(posedge sys_clk) begin
		feed_k_reg <= rst ? 8'h00 : feed_k_next;
		sum_elem   <= mk_sum(rst ? 8'h00 : feed_k_next);
		raw_elem   <= mk_raw(rst ? 8'h00 : feed_k_next);
	end

	// Expected bytes, least significant first
	task automatic put(input logic [63:0] v, input int nb);
		for (int i = 0; i < nb; i++)
			exp_q.push_back('{data: v[8*i +: 8], last: 1'b0});
	endtask

	// ============================================================
	// One record: build its image, start it, wait for it to drain
	task automatic run_rec(input logic raw, input logic [7:0] n, input logic slw);
		gsrc_sum_elem_t s;
		gsrc_raw_elem_t r;
		raw_kind <= raw;
		slow <= slw;
		if (raw)
			put(tow_seconds, 8);
		if (raw)
			put({8'h00, n, gps_week}, 4);
		else
			put({8'h00, n}, 2);
		for (int i = 0; i < n; i++) begin
			s = mk_sum(8'(i));
			r = mk_raw(8'(i));
			if (raw) begin
				put({r.cn0_dbhz, r.slot_id, r.channel_code, r.band_code, r.vehicle_id, r.constellation}, 6);
				put({r.pseudorange[47:0], r.track_flags}, 8);
				put({r.carrier_phase[47:0], r.pseudorange[63:48]}, 8);
				put({r.doppler_shift, r.carrier_phase[63:48]}, 6);
			end else begin
				put({s.azimuth_deg, s.elevation_deg, s.quality_code, s.cn0_dbhz,
					s.track_flags & `GSRC_FLG_MASK, s.vehicle_id, s.constellation}, 8);
			end
		end
		exp_q[exp_q.size() - 1].last = 1'b1;
		axi_wr(`GSRC_REG_CTRL, {16'h0000, n, 6'h00, raw, 1'b1});
		while (exp_q.size() != 0)
			@(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
		chk("record length", {31'h0, len_ok}, 32'h1);
	endtask

	// Byte monitor: the byte present at a taking edge is compared mid-cycle before it
	always @(negedge sys_clk) begin
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("spare byte", 32'h1, 32'h0);
			else
				chk("stream byte", {23'h0, out_byte}, {23'h0, exp_q.pop_front()});
		end
	end

	// ============================================================
	// Clock, hang guard and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Whole run is under a thousand cycles; the ceiling leaves ample margin
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	initial begin
		{rst, elem_valid, slow, raw_kind} = 4'h8;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr, s_wstrb, s_wdata} = {8'h00, 4'hF, 32'h0};
		{tow_seconds, gps_week} = {64'h4112_3456_789A_BCDE, 16'h0913};
		n_mismatch = 0;
		num_checks = 0;
		cyc = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		elem_valid <= 1'b1;
		axi_rd(`GSRC_REG_CTRL, rd);
		chk("ctrl reset", rd, `GSRC_CTRL_RESET);
		axi_wr(4'hC, 32'hFFFF_FFFF);
		axi_rd(4'hC, rd);
		chk("unmapped read", rd, 32'h0);
		axi_rd(`GSRC_REG_COUNT, rd);
		chk("count reset", rd, 32'h0);
		run_rec(1'b0, 8'h00, 1'b0);
		run_rec(1'b0, 8'h08, 1'b1);
		run_rec(1'b1, 8'h0F, 1'b0);
		run_rec(1'b1, 8'h01, 1'b1);
		run_rec(1'b0, 8'h01, 1'b0);
		axi_rd(`GSRC_REG_COUNT, rd);
		chk("records done", rd, 32'h5);
		axi_rd(`GSRC_REG_STATUS, rd);
		chk("busy after drain", {31'h0, rd[0]}, 32'h0);
		results();
	end
endmodule
